// File: rtl/tifp_top.sv
// timer interrupt flags, capture register with shared high-byte temp, shared prescaler
// assumes counter core outside supplies counter value and match/overflow events
`timescale 1ns/1ps
`default_nettype none
`include "tifp_regs.svh"
module tifp_top
  import tifp_pkg::*;
#(
  parameter int NUM_TIMERS = 3,
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TIFP_ADDR_W+1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic capture_pin_event,
  input wire logic comparator_event,
  input wire logic counter_at_top,
  input wire logic compare_a_match,
  input wire logic compare_b_match,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  input wire logic counter_overflow,
  input wire logic mode_overflow_event,
  input wire logic timer_tick,
  input wire logic [3:0] vector_ack,
  input wire logic [NUM_TIMERS-1:0] external_count_pin,
  output logic [NUM_TIMERS-1:0] count_tick,
  output logic [3:0] irq_request
);
  initial begin
    if (NUM_TIMERS < 1 || NUM_TIMERS > 8 || CNT_W != 16) begin
      $error("tifp_top: unsupported parameters");
    end
  end

  // bus decode
  logic bus_req, wr_stb, rd_stb;
  logic [`TIFP_ADDR_W-1:0] reg_idx;
  logic [7:0] wbyte;
  logic lane0;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign reg_idx = wb_adr_i[`TIFP_ADDR_W+1:2];
  assign lane0 = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign wr_stb = bus_req && wb_we_i && lane0;
  assign rd_stb = bus_req && !wb_we_i;

  logic wr_mask, wr_flags, wr_gtc, wr_csel, wr_ctrl, rd_cap_lo;
  assign wr_mask = wr_stb && (reg_idx == `TIFP_OFF_MASK);
  assign wr_flags = wr_stb && (reg_idx == `TIFP_OFF_FLAGS);
  assign wr_gtc = wr_stb && (reg_idx == `TIFP_OFF_GTC);
  assign wr_csel = wr_stb && (reg_idx == `TIFP_OFF_CSEL);
  assign wr_ctrl = wr_stb && (reg_idx == `TIFP_OFF_CTRL);
  assign rd_cap_lo = rd_stb && (reg_idx == `TIFP_OFF_CAP_LO);

  // registers
  logic [7:0] mask_q, flags_q, flags_d, ctrl_q, temp_q, gtc_q, gtc_d;
  logic [CNT_W-1:0] cap_q;
  logic [3*NUM_TIMERS-1:0] csel_q;
  logic [`TIFP_PS_W-1:0] ps_q, ps_d;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mask_q <= `TIFP_RST_BYTE;
      ctrl_q <= `TIFP_RST_BYTE;
    end else begin
      if (wr_mask) begin
        mask_q <= wbyte & `TIFP_MASK_USED;
      end
      if (wr_ctrl) begin
        ctrl_q <= wbyte;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      csel_q <= '0;
    end else if (wr_csel) begin
      csel_q <= wb_dat_i[3*NUM_TIMERS-1:0];
    end
  end

  // capture: comparator path chosen by control; disabled when capture is top
  logic cap_event;
  assign cap_event = !ctrl_q[`TIFP_BIT_ICTOP]
    && (ctrl_q[`TIFP_BIT_ACSEL] ? comparator_event : capture_pin_event);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_q <= '0;
    end else if (cap_event) begin
      cap_q <= counter_value;
    end
  end

  // low-byte read latches the high byte so a later high read is coherent
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      temp_q <= `TIFP_RST_BYTE;
    end else if (rd_cap_lo) begin
      temp_q <= cap_q[15:8];
    end
  end

  // flag sets; compare matches only count on a timer tick, forced strobes masked
  logic [7:0] flag_set, flag_clr;
  logic set_cap, set_a, set_b, set_ovf;
  assign set_cap = ctrl_q[`TIFP_BIT_ICTOP] ? counter_at_top : cap_event;
  assign set_a = timer_tick && compare_a_match && !force_compare_a;
  assign set_b = timer_tick && compare_b_match && !force_compare_b;
  assign set_ovf = ctrl_q[`TIFP_BIT_NORMAL] ? counter_overflow
                                             : mode_overflow_event;
  always_comb begin
    flag_set = '0;
    flag_set[`TIFP_BIT_CAP] = set_cap;
    flag_set[`TIFP_BIT_CMPB] = set_b;
    flag_set[`TIFP_BIT_CMPA] = set_a;
    flag_set[`TIFP_BIT_OVF] = set_ovf;
    flag_clr = wr_flags ? wbyte : 8'h00;
    flag_clr[`TIFP_BIT_CAP] = flag_clr[`TIFP_BIT_CAP] | vector_ack[3];
    flag_clr[`TIFP_BIT_CMPB] = flag_clr[`TIFP_BIT_CMPB] | vector_ack[2];
    flag_clr[`TIFP_BIT_CMPA] = flag_clr[`TIFP_BIT_CMPA] | vector_ack[1];
    flag_clr[`TIFP_BIT_OVF] = flag_clr[`TIFP_BIT_OVF] | vector_ack[0];
    flags_d = ((flags_q & ~flag_clr) | flag_set) & `TIFP_MASK_USED;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_q <= `TIFP_RST_BYTE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // interrupt requests
  logic gie;
  logic [3:0] irq_d;
  assign gie = ctrl_q[`TIFP_BIT_GIE];
  assign irq_d[3] = gie && mask_q[`TIFP_BIT_CAP] && flags_q[`TIFP_BIT_CAP];
  assign irq_d[2] = gie && mask_q[`TIFP_BIT_CMPB] && flags_q[`TIFP_BIT_CMPB];
  assign irq_d[1] = gie && mask_q[`TIFP_BIT_CMPA] && flags_q[`TIFP_BIT_CMPA];
  assign irq_d[0] = gie && mask_q[`TIFP_BIT_OVF] && flags_q[`TIFP_BIT_OVF];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_request <= '0;
    end else begin
      irq_request <= irq_d;
    end
  end

  // general control: psr self-clears unless sync mode holds it
  always_comb begin
    gtc_d = gtc_q;
    if (wr_gtc) begin
      gtc_d = 8'h00;
      gtc_d[`TIFP_BIT_TSM] = wbyte[`TIFP_BIT_TSM];
      gtc_d[`TIFP_BIT_PSR] = wbyte[`TIFP_BIT_PSR] && wbyte[`TIFP_BIT_TSM];
    end else if (!gtc_q[`TIFP_BIT_TSM]) begin
      gtc_d[`TIFP_BIT_PSR] = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gtc_q <= `TIFP_RST_BYTE;
    end else begin
      gtc_q <= gtc_d;
    end
  end

  // free-running prescaler, cleared while reset bit written or held
  logic ps_clear;
  assign ps_clear = gtc_q[`TIFP_BIT_PSR] || (wr_gtc && wbyte[`TIFP_BIT_PSR]);
  assign ps_d = ps_clear ? '0 : ps_q + 1'b1;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ps_q <= '0;
    end else begin
      ps_q <= ps_d;
    end
  end

  // taps fire when the low bits reach all ones, the cycle before they wrap to zero
  logic tap8, tap64, tap256, tap1024;
  assign tap8 = !ps_clear && ((ps_q & `TIFP_DIV8_MSK) == `TIFP_DIV8_MSK);
  assign tap64 = !ps_clear && ((ps_q & `TIFP_DIV64_MSK) == `TIFP_DIV64_MSK);
  assign tap256 = !ps_clear && ((ps_q & `TIFP_DIV256_MSK) == `TIFP_DIV256_MSK);
  assign tap1024 = !ps_clear && ((ps_q & `TIFP_DIV1024_MSK) == `TIFP_DIV1024_MSK);

  // per-timer pin sampling, edge detect and source select
  genvar t;
  generate
    for (t = 0; t < NUM_TIMERS; t = t + 1) begin : g_tmr
      logic s1_q, s2_q, s3_q, tick_d;
      logic rise, fall;
      tifp_csel_type cs;
      assign cs = tifp_csel_type'(csel_q[3*t+2:3*t]);
      assign rise = s2_q && !s3_q;
      assign fall = !s2_q && s3_q;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= external_count_pin[t];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      always_comb begin
        case (cs)
          TIFP_CS_STOP: tick_d = 1'b0;
          TIFP_CS_DIV1: tick_d = !ps_clear;
          TIFP_CS_DIV8: tick_d = tap8;
          TIFP_CS_DIV64: tick_d = tap64;
          TIFP_CS_DIV256: tick_d = tap256;
          TIFP_CS_DIV1024: tick_d = tap1024;
          TIFP_CS_EXT_FALL: tick_d = fall;
          TIFP_CS_EXT_RISE: tick_d = rise;
          default: tick_d = 1'b0;
        endcase
      end
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          count_tick[t] <= 1'b0;
        end else begin
          count_tick[t] <= tick_d;
        end
      end
    end
  endgenerate

  // read mux and single-wait ack
  logic [7:0] rd_byte;
  always_comb begin
    case (reg_idx)
      `TIFP_OFF_MASK: rd_byte = mask_q;
      `TIFP_OFF_FLAGS: rd_byte = flags_q;
      `TIFP_OFF_CAP_LO: rd_byte = cap_q[7:0];
      `TIFP_OFF_CAP_HI: rd_byte = temp_q;
      `TIFP_OFF_GTC: rd_byte = gtc_q;
      `TIFP_OFF_CSEL: rd_byte = 8'(csel_q);
      `TIFP_OFF_CTRL: rd_byte = ctrl_q;
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_stb ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tifp_regs.svh
// register offsets, field positions and reset values of the timer flag/prescaler block
// assumes classic wishbone with 32-bit data, one register per aligned word
`ifndef TIFP_REGS_SVH
`define TIFP_REGS_SVH
`define TIFP_ADDR_W 4
`define TIFP_OFF_MASK 4'h0
`define TIFP_OFF_FLAGS 4'h1
`define TIFP_OFF_CAP_LO 4'h2
`define TIFP_OFF_CAP_HI 4'h3
`define TIFP_OFF_GTC 4'h4
`define TIFP_OFF_CSEL 4'h5
`define TIFP_OFF_CTRL 4'h6
`define TIFP_BIT_CAP 5
`define TIFP_BIT_CMPB 2
`define TIFP_BIT_CMPA 1
`define TIFP_BIT_OVF 0
`define TIFP_BIT_TSM 7
`define TIFP_BIT_PSR 0
`define TIFP_BIT_GIE 0
`define TIFP_BIT_ACSEL 1
`define TIFP_BIT_ICTOP 2
`define TIFP_BIT_NORMAL 3
`define TIFP_MASK_USED 8'h27
`define TIFP_RST_BYTE 8'h00
`define TIFP_PS_W 10
`define TIFP_DIV8_MSK 10'h007
`define TIFP_DIV64_MSK 10'h03f
`define TIFP_DIV256_MSK 10'h0ff
`define TIFP_DIV1024_MSK 10'h3ff
`endif

// File: rtl/tifp_pkg.sv
// types shared by the timer flag/prescaler block
// assumes tifp_regs.svh supplies the numeric constants
package tifp_pkg;
  typedef enum logic [2:0] {
    TIFP_CS_STOP, TIFP_CS_DIV1, TIFP_CS_DIV8, TIFP_CS_DIV64,
    TIFP_CS_DIV256, TIFP_CS_DIV1024, TIFP_CS_EXT_FALL, TIFP_CS_EXT_RISE
  } tifp_csel_type;
  typedef enum logic [1:0] {TIFP_BUS_IDLE, TIFP_BUS_ACK} tifp_bus_type;
endpackage

// File: testbench/tifp_top_monitor.sv
// assertion checker for the timer flag block, sees only top ports
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module tifp_top_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic capture_pin_event,
  input wire logic comparator_event,
  input wire logic counter_at_top,
  input wire logic compare_a_match,
  input wire logic force_compare_a,
  input wire logic counter_overflow,
  input wire logic mode_overflow_event,
  input wire logic timer_tick,
  input wire logic [3:0] vector_ack,
  input wire logic [3:0] irq_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire req = wb_cyc_i && wb_stb_i;
  wire ovf_ev = counter_overflow || mode_overflow_event;
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // an irq may also rise because software opened the mask or global enable
  chk_ovf_cause: assert property ($rose(irq_request[0]) |-> $past(ovf_ev, 2) || $past(req, 2))
    else $error("overflow irq without cause");
  chk_cmpa_cause: assert property ($rose(irq_request[1]) |->
    $past(compare_a_match && timer_tick && !force_compare_a, 2) || $past(req, 2))
    else $error("compare a irq without timed match");
  chk_cap_cause: assert property ($rose(irq_request[3]) |->
    $past(capture_pin_event || comparator_event || counter_at_top, 2) || $past(req, 2))
    else $error("capture irq without cause");
  chk_ovf_vec_clear: assert property (vector_ack[0] && !ovf_ev |=> ##1 !irq_request[0])
    else $error("overflow irq stays after vector");
endmodule
`default_nettype wire

// File: testbench/tifp_cpu_model.sv
// processor core model: takes the lowest pending interrupt when enabled
// assumes irq_request falls two edges after a vector pulse
`timescale 1ns/1ps
`default_nettype none
module tifp_cpu_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [3:0] irq_request,
  output logic [3:0] vector_ack
);
  logic [1:0] hold_q;
  // holdoff covers the clear path so one request is not taken twice
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vector_ack <= 4'h0;
      hold_q <= 2'h0;
    end else if (enable && hold_q == 2'h0 && irq_request != 4'h0) begin
      vector_ack <= irq_request & (~irq_request + 4'h1);
      hold_q <= 2'h3;
    end else begin
      vector_ack <= 4'h0;
      hold_q <= hold_q - {1'b0, hold_q != 2'h0};
    end
  end
endmodule
`default_nettype wire

// File: testbench/tifp_top_tb.sv
// self-checking bench for tifp_top: wishbone tasks, event pulses, tick counts
// assumes the cpu model answers interrupts only while enabled
`timescale 1ns/1ps
`default_nettype none
module tifp_top_tb;
  logic ref_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, cpu_en = 0, ack;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [15:0] cnt_val = 16'h0;
  logic [9:0] ev = 10'h0;
  logic [2:0] pin = 3'h0, tick;
  logic [3:0] irq, vack;
  logic [7:0] rb;
  int errors = 0, cmp_count = 0, n;
  int exp_t[8] = '{0, 1024, 128, 16, 4, 1, 12, 12};
  initial forever #25 ref_clk = ~ref_clk;
  tifp_top dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .counter_value(cnt_val), .capture_pin_event(ev[0]),
    .comparator_event(ev[1]), .counter_at_top(ev[2]), .compare_a_match(ev[3]),
    .compare_b_match(ev[4]), .force_compare_a(ev[5]), .force_compare_b(ev[6]),
    .counter_overflow(ev[7]), .mode_overflow_event(ev[8]), .timer_tick(ev[9]),
    .vector_ack(vack), .external_count_pin(pin), .count_tick(tick), .irq_request(irq));
  tifp_cpu_model cpu (.ref_clk(ref_clk), .reset(reset), .enable(cpu_en),
    .irq_request(irq), .vector_ack(vack));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, 24'h0, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge ref_clk);
    if (ack !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    rb = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, {8'h00, exp}, {8'h00, rb});
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= 10'h0;
  endtask
  // pin half period is four clocks and it is quiet at every select change except the one after the 64-clock count
  task automatic count(input int len);
    n = 0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < len; i++) begin
      @(posedge ref_clk);
      pin <= {3{i < 96 && i[2]}};
      n += tick[0];
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rchk("mask", 4'h0, 8'h00);
    rchk("flags", 4'h1, 8'h00);
    rchk("general", 4'h4, 8'h00);
    bus(1'b1, 4'h0, 8'hff);
    rchk("mask", 4'h0, 8'h27);
    bus(1'b1, 4'h6, 8'h0b);
    cnt_val <= 16'h1234;
    pulse(10'h002);
    rchk("cap lo", 4'h2, 8'h34);
    rchk("cap hi", 4'h3, 8'h12);
    bus(1'b1, 4'h6, 8'h09);
    cnt_val <= 16'habcd;
    pulse(10'h001);
    rchk("cap lo", 4'h2, 8'hcd);
    cnt_val <= 16'h5678;
    pulse(10'h001);
    rchk("cap hi", 4'h3, 8'hab);
    $display("capture test done");
    pulse(10'h228);
    pulse(10'h250);
    rchk("flags", 4'h1, 8'h20);
    pulse(10'h288);
    rchk("flags", 4'h1, 8'h23);
    chk("irq", 16'hb, {12'h0, irq});
    pulse(10'h210);
    // flag lands one edge after the event, the request one edge later
    repeat (2) @(posedge ref_clk);
    chk("irq", 16'hf, {12'h0, irq});
    bus(1'b1, 4'h1, 8'h25);
    rchk("flags", 4'h1, 8'h02);
    bus(1'b1, 4'h6, 8'h08);
    repeat (2) @(posedge ref_clk);
    chk("irq", 16'h0, {12'h0, irq});
    bus(1'b1, 4'h6, 8'h09);
    pulse(10'h081);
    cpu_en <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rchk("flags", 4'h1, 8'h00);
    cpu_en <= 1'b0;
    // capture as top: pin capture blocked, top sets the flag; other modes use mode event
    bus(1'b1, 4'h6, 8'h05);
    pulse(10'h081);
    rchk("flags", 4'h1, 8'h00);
    pulse(10'h104);
    rchk("flags", 4'h1, 8'h21);
    bus(1'b1, 4'h1, 8'h21);
    rchk("flags", 4'h1, 8'h00);
    bus(1'b1, 4'h6, 8'h09);
    bus(1'b1, 4'h7, 8'hff);
    rchk("unmapped", 4'h7, 8'h00);
    $display("flag test done");
    bus(1'b1, 4'h4, 8'h81);
    rchk("general", 4'h4, 8'h81);
    bus(1'b1, 4'h5, 8'h01);
    count(64);
    chk("held ticks", 16'h0, n[15:0]);
    bus(1'b1, 4'h4, 8'h00);
    rchk("general", 4'h4, 8'h00);
    bus(1'b1, 4'h4, 8'h01);
    rchk("general", 4'h4, 8'h00);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 4'h5, 8'(c));
      count(1024);
      chk("ticks", 16'(exp_t[c]), n[15:0]);
    end
    $display("prescaler test done");
    report_and_stop();
  end
endmodule
bind tifp_top tifp_top_monitor mon (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .capture_pin_event(capture_pin_event), .comparator_event(comparator_event),
  .counter_at_top(counter_at_top), .compare_a_match(compare_a_match),
  .force_compare_a(force_compare_a), .counter_overflow(counter_overflow),
  .mode_overflow_event(mode_overflow_event), .timer_tick(timer_tick),
  .vector_ack(vector_ack), .irq_request(irq_request));
`default_nettype wire
